//--- arf_top.sv
// Purpose: control, status and result-format registers of a 10-bit converter
// Assumes: sample code and trigger come from an external analog front end
// Notes:   one answer per access: waitrequest low one cycle after request rises
//
// Added by the designer: the register offsets and register access over Avalon-MM.
module arf_top #(
   parameter int CONV_CYC = arf_pkg::ARF_CONV_CYC
) (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     srst,
   // register bus
   input  wire arf_pkg::arf_bus_req_type bus_req,
   output      arf_pkg::arf_bus_rsp_type bus_rsp,
   // analog front end
   input  wire logic [9:0]               sample_code,
   input  wire logic                     special_trigger,
   output      logic                     conversion_active,
   // interrupt
   output      logic                     irq
);
   import arf_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [7:0]    ctrl0;
      logic [7:0]    ctrl1;
      logic [7:0]    ctrl2;
      logic [7:0]    res_hi;
      logic [7:0]    res_lo;
      logic          irq_st;
      logic          irq_msk;
      arf_state_type fsm;
      logic [15:0]   cnt;
      logic [1:0]    trig_sync;
      logic          trig_prev;
      logic [31:0]   rdata;
      logic          ack;
      // waitrequest kept in its own flop so the pin comes straight from a register
      logic          wreq;
      logic [1:0][9:0] code_sync;
      logic          irq_out;
      logic          active;
   } arf_regs_type;

   arf_regs_type s_q;
   arf_regs_type s_d;
   logic         trig_rise;
   logic         go_req;
   logic         done;

   function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] mask);
      wr_merge = bus_req.byteenable[0] ? (bus_req.writedata[7:0] & mask) : old;
   endfunction

   function automatic logic is_access(input logic [4:0] ofs);
      is_access = bus_req.address == ofs;
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      // the synchroniser's first stage feeds only the second
      s_d.trig_sync = {s_q.trig_sync[0], special_trigger};
      s_d.trig_prev = s_q.trig_sync[1];
      // code comes from the analog side; it is stable long before completion
      s_d.code_sync = {s_q.code_sync[0], sample_code};
      trig_rise     = s_q.trig_sync[1] & ~s_q.trig_prev;
      go_req        = 1'b0;
      done          = 1'b0;
      s_d.ack       = 1'b0;

      // bus: answer one cycle after request; ack drops the request-taken edge
      if ((bus_req.read | bus_req.write) & ~s_q.ack) begin
         s_d.ack   = 1'b1;
         s_d.rdata = 32'h0000_0000;
         if (bus_req.write) begin
            case (bus_req.address)
               ARF_OFS_CTRL0: begin
                  s_d.ctrl0 = wr_merge(s_q.ctrl0, ARF_MASK_CTRL0);
                  // go cannot be cleared by software while busy
                  s_d.ctrl0[ARF_BIT_GO] = s_q.ctrl0[ARF_BIT_GO];
                  go_req = bus_req.byteenable[0] & bus_req.writedata[ARF_BIT_GO];
               end
               ARF_OFS_CTRL1: s_d.ctrl1 = wr_merge(s_q.ctrl1, ARF_MASK_CTRL1);
               ARF_OFS_CTRL2: s_d.ctrl2 = wr_merge(s_q.ctrl2, ARF_MASK_CTRL2);
               ARF_OFS_RES_HI: s_d.res_hi = wr_merge(s_q.res_hi, 8'hFF);
               ARF_OFS_RES_LO: s_d.res_lo = wr_merge(s_q.res_lo, 8'hFF);
               ARF_OFS_IRQ_ST: begin
                  if (bus_req.byteenable[0] & bus_req.writedata[0]) begin
                     s_d.irq_st = 1'b0;
                  end
               end
               ARF_OFS_IRQ_MSK: begin
                  if (bus_req.byteenable[0]) begin
                     s_d.irq_msk = bus_req.writedata[0];
                  end
               end
               default: ;
            endcase
         end else begin
            case (bus_req.address)
               ARF_OFS_CTRL0:   s_d.rdata = {24'h000000, s_q.ctrl0};
               ARF_OFS_CTRL1:   s_d.rdata = {24'h000000, s_q.ctrl1};
               ARF_OFS_CTRL2:   s_d.rdata = {24'h000000, s_q.ctrl2};
               ARF_OFS_RES_HI:  s_d.rdata = {24'h000000, s_q.res_hi};
               ARF_OFS_RES_LO:  s_d.rdata = {24'h000000, s_q.res_lo};
               ARF_OFS_IRQ_ST:  s_d.rdata = {31'h00000000, s_q.irq_st};
               ARF_OFS_IRQ_MSK: s_d.rdata = {31'h00000000, s_q.irq_msk};
               default:         s_d.rdata = 32'h0000_0000;
            endcase
         end
      end

      // converter off: triggers and go requests are disregarded
      if (!s_d.ctrl0[ARF_BIT_ON]) begin
         go_req = 1'b0;
      end else if (trig_rise) begin
         go_req = 1'b1;
      end

      // ****************************************************************
      // conversion sequencer
      // ****************************************************************
      case (s_q.fsm)
         ARF_IDLE: begin
            if (go_req) begin
               s_d.ctrl0[ARF_BIT_GO] = 1'b1;
               s_d.cnt = 16'h0000;
               if (s_d.ctrl2[2:0] == ARF_CLK_INT_A || s_d.ctrl2[2:0] == ARF_CLK_INT_B) begin
                  s_d.fsm = ARF_DELAY;
               end else begin
                  s_d.fsm = ARF_CONV;
               end
            end
         end
         ARF_DELAY: begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == 16'(ARF_INSTR_CYC - 1)) begin
               s_d.cnt = 16'h0000;
               s_d.fsm = ARF_CONV;
            end
         end
         ARF_CONV: begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (!s_q.ctrl0[ARF_BIT_ON]) begin
               // turning the converter off aborts without a result
               s_d.ctrl0[ARF_BIT_GO] = 1'b0;
               s_d.fsm = ARF_IDLE;
            end else if (s_q.cnt == 16'(CONV_CYC - 1)) begin
               done = 1'b1;
               s_d.fsm = ARF_DONE;
               // the synchronised code is a ten-bit unsigned value from the front end
               if (s_q.ctrl2[ARF_BIT_JUSTIFY]) begin
                  s_d.res_hi = {6'h00, s_q.code_sync[1][9:8]};
                  s_d.res_lo = s_q.code_sync[1][7:0];
               end else begin
                  s_d.res_hi = s_q.code_sync[1][9:2];
                  s_d.res_lo = {s_q.code_sync[1][1:0], 6'h00};
               end
            end
         end
         ARF_DONE: begin
            // results landed last cycle, go clears only now
            s_d.ctrl0[ARF_BIT_GO] = 1'b0;
            s_d.fsm = ARF_IDLE;
         end
         default: s_d.fsm = ARF_IDLE;
      endcase

      // set wins over a same-cycle clear
      if (done) begin
         s_d.irq_st = 1'b1;
      end

      s_d.irq_out = s_d.irq_st & s_d.irq_msk;
      s_d.wreq    = ~s_d.ack;
      s_d.active  = s_d.fsm != ARF_IDLE;

      if (srst) begin
         s_d           = '0;
         s_d.ctrl0     = ARF_RST_CTRL;
         s_d.ctrl1     = ARF_RST_CTRL;
         s_d.ctrl2     = ARF_RST_CTRL;
         s_d.res_hi    = s_q.res_hi; // undefined after reset: left as is
         s_d.res_lo    = s_q.res_lo;
         s_d.fsm       = ARF_IDLE;
         s_d.wreq      = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign bus_rsp.readdata    = s_q.rdata;
   assign bus_rsp.waitrequest = s_q.wreq;
   assign conversion_active   = s_q.active;
   assign irq                 = s_q.irq_out;
endmodule

//--- arf_pkg.sv
// Purpose: constants and types of the converter result-format register block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one register per word
// Notes:   8-bit registers sit in the low bits of each word; upper bits read zero
// Function
// - left justified: result bits 9..2 fill the high result byte
// - left justified: result bits 1..0 go to low byte bits 7..6
// - right justified: result bits 9..8 go to high byte bits 1..0
// - right justified: result bits 7..0 fill the low result byte
// - both result bytes are software read/write, undefined until first conversion
// - each conversion yields a ten-bit unsigned code, 1024 possible values
// - unimplemented control register bits read back as zero
// - justify select one means right justified, zero means left justified
// - setting go/busy starts a conversion; hardware clears it when done
// - with converter off, triggers are ignored and nothing starts
// - internal oscillator clock delays conversion start by one instruction cycle
package arf_pkg;
   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [4:0] ARF_OFS_CTRL0   = 5'h00;
   localparam logic [4:0] ARF_OFS_CTRL1   = 5'h04;
   localparam logic [4:0] ARF_OFS_CTRL2   = 5'h08;
   localparam logic [4:0] ARF_OFS_RES_HI  = 5'h0C;
   localparam logic [4:0] ARF_OFS_RES_LO  = 5'h10;
   localparam logic [4:0] ARF_OFS_IRQ_ST  = 5'h14;
   localparam logic [4:0] ARF_OFS_IRQ_MSK = 5'h18;

   // ****************************************************************
   // field positions and writable masks
   // ****************************************************************
   localparam int         ARF_BIT_ON      = 0;
   localparam int         ARF_BIT_GO      = 1;
   localparam int         ARF_BIT_JUSTIFY = 7;
   localparam logic [7:0] ARF_MASK_CTRL0  = 8'h7F;
   localparam logic [7:0] ARF_MASK_CTRL1  = 8'h8F;
   localparam logic [7:0] ARF_MASK_CTRL2  = 8'hBF;
   localparam logic [2:0] ARF_CLK_INT_A   = 3'h3;
   localparam logic [2:0] ARF_CLK_INT_B   = 3'h7;

   // ****************************************************************
   // reset values and timing
   // ****************************************************************
   localparam logic [7:0] ARF_RST_CTRL    = 8'h00;
   localparam logic [7:0] ARF_RST_RESULT  = 8'h00;
   localparam int         ARF_CLK_MHZ     = 50;
   localparam int         ARF_INSTR_NS    = 80;
   localparam int         ARF_INSTR_CYC   = (ARF_INSTR_NS * ARF_CLK_MHZ + 999) / 1000;
   localparam int         ARF_CONV_CYC    = 24;

   typedef enum logic [1:0] {
      ARF_IDLE  = 2'b00,
      ARF_DELAY = 2'b01,
      ARF_CONV  = 2'b11,
      ARF_DONE  = 2'b10
   } arf_state_type;

   typedef struct packed {
      logic [4:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } arf_bus_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } arf_bus_rsp_type;
endpackage

//--- arf_props.sv
// Purpose: port-level timing checks of arf_top
// Assumes: the bench never aborts a running conversion
// Notes:   bound to arf_top from the bench top file
module arf_props #(
   parameter int CONV_CYC = arf_pkg::ARF_CONV_CYC
) (
   // clock and reset
   input wire logic                     clk_sys,
   input wire logic                     srst,
   // register bus
   input wire arf_pkg::arf_bus_req_type bus_req,
   input wire arf_pkg::arf_bus_rsp_type bus_rsp,
   // front end and interrupt
   input wire logic                     special_trigger,
   input wire logic                     conversion_active,
   input wire logic                     irq
);
   import arf_pkg::*;
   // ****************************************
   // helper logic and properties
   // ****************************************
   logic [7:0] act_cnt_q;
   logic       req;
   logic       wr0;
   assign req = bus_req.read || bus_req.write;
   // a write to control 0 on its taking edge
   assign wr0 = bus_req.write && bus_rsp.waitrequest && bus_req.address == ARF_OFS_CTRL0;
   always_ff @(posedge clk_sys) act_cnt_q <= conversion_active ? act_cnt_q + 8'h01 : 8'h00;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   chk_wait_answer: assert property (req && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
      else $error("no answer one cycle after request");
   chk_wait_single: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
      else $error("answer held longer than one cycle");
   chk_wait_idle: assert property (!req |=> bus_rsp.waitrequest)
      else $error("answer without request");
   chk_upper_zero: assert property (!bus_rsp.waitrequest |-> bus_rsp.readdata[31:8] == 24'h0)
      else $error("unused read data bits not zero");
   chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !irq && !conversion_active)
      else $error("outputs active after reset");
   chk_off_no_start: assert property (wr0 && !bus_req.writedata[ARF_BIT_ON] && !conversion_active
      && !special_trigger |=> !conversion_active [*3])
      else $error("conversion started while converter off");
   chk_go_start: assert property (wr0 && bus_req.byteenable[0] && bus_req.writedata[1:0] == 2'b11
      && !conversion_active
      |-> ##[1:3] conversion_active)
      else $error("go write did not start a conversion");
   chk_conv_length: assert property ($fell(conversion_active)
      |-> act_cnt_q >= CONV_CYC - 1 && act_cnt_q <= CONV_CYC + 8)
      else $error("conversion length out of range");
   cover property ($fell(conversion_active));
   cover property ($rose(irq));
   cover property (bus_req.read && !bus_rsp.waitrequest);
endmodule

//--- tb.sv
// Purpose: self-checking bench of arf_top registers and conversions
// Assumes: conversion length shortened to 4 cycles
// Notes:   no conversion is aborted, so the length check stays valid
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import arf_pkg::*;
   // ****************************************
   // signals, design and tasks
   // ****************************************
   localparam int   CONV = 4;
   logic            clk_sys = 1'b0;
   logic            srst = 1'b1;
   arf_bus_req_type bus_req = '0;
   arf_bus_rsp_type bus_rsp;
   logic [9:0]      sample_code = 10'h000;
   logic            special_trigger = 1'b0;
   logic            conversion_active;
   logic            irq;
   logic [7:0]      rd;
   logic            j;
   int              miscompares = 0;
   int              total_checks = 0;
   int              act_cycles = 0;
   int              act_base;
   int              act_len [4];
   logic [4:0]      ofs [5] = '{ARF_OFS_CTRL0, ARF_OFS_CTRL1, ARF_OFS_CTRL2, ARF_OFS_IRQ_ST,
                                ARF_OFS_IRQ_MSK};
   // normal left, internal-oscillator right, internal-oscillator left, normal right
   logic [7:0]      cfg [4] = '{8'h00, 8'h83, 8'h07, 8'h81};
   logic [9:0]      code [4] = '{10'h2B5, 10'h16A, 10'h3FF, 10'h000};
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (conversion_active === 1'b1) act_cycles <= act_cycles + 1;
   arf_top #(.CONV_CYC(CONV)) arf_top_inst (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
      .bus_rsp(bus_rsp), .sample_code(sample_code), .special_trigger(special_trigger),
      .conversion_active(conversion_active), .irq(irq));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // request held until the edge that sees waitrequest low
   task automatic xfer(input logic [4:0] a, input logic wr, input logic [7:0] wd);
      int n;
      n = 0;
      bus_req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, wd}, byteenable: 4'hF};
      do begin
         @(posedge clk_sys);
         n++;
      end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
      rd = bus_rsp.readdata[7:0];
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
      if (n >= 50) miscompares++;
      @(posedge clk_sys);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string name);
      xfer(a, 1'b0, 8'h00);
      check(name, {24'h0, rd}, {24'h0, exp});
   endtask
   task automatic pulse;
      special_trigger <= 1'b1;
      repeat (3) @(posedge clk_sys);
      special_trigger <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      foreach (ofs[i]) rd_chk(ofs[i], 8'h00, "reset value");
      check("irq after reset", {31'h0, irq}, 32'h0);
      xfer(ARF_OFS_CTRL1, 1'b1, 8'hFF);
      rd_chk(ARF_OFS_CTRL1, ARF_MASK_CTRL1, "ctrl1 unused bits");
      xfer(ARF_OFS_CTRL2, 1'b1, 8'hFF);
      rd_chk(ARF_OFS_CTRL2, ARF_MASK_CTRL2, "ctrl2 unused bits");
      xfer(ARF_OFS_CTRL0, 1'b1, 8'hFE);
      rd_chk(ARF_OFS_CTRL0, 8'h7C, "go while off");
      xfer(5'h1C, 1'b1, 8'hFF);
      rd_chk(5'h1C, 8'h00, "unmapped");
      xfer(ARF_OFS_RES_HI, 1'b1, 8'h5A);
      rd_chk(ARF_OFS_RES_HI, 8'h5A, "result high rw");
      xfer(ARF_OFS_RES_LO, 1'b1, 8'hA5);
      rd_chk(ARF_OFS_RES_LO, 8'hA5, "result low rw");
      xfer(ARF_OFS_CTRL0, 1'b1, 8'h00);
      pulse();
      check("trigger while off", {31'h0, conversion_active}, 32'h0);
      xfer(ARF_OFS_IRQ_MSK, 1'b1, 8'h01);
      for (int i = 0; i < 4; i++) begin
         xfer(ARF_OFS_CTRL2, 1'b1, cfg[i]);
         sample_code <= code[i];
         xfer(ARF_OFS_CTRL0, 1'b1, 8'h05);
         repeat (8) @(posedge clk_sys);
         act_base = act_cycles;
         if (i == 3) pulse();
         else xfer(ARF_OFS_CTRL0, 1'b1, 8'h07);
         for (int n = 0; n < 40 && (n == 0 || rd[ARF_BIT_GO] !== 1'b0); n++) xfer(ARF_OFS_CTRL0, 1'b0, 8'h00);
         check("go cleared", {31'h0, rd[ARF_BIT_GO]}, 32'h0);
         act_len[i] = act_cycles - act_base;
         j = cfg[i][ARF_BIT_JUSTIFY];
         rd_chk(ARF_OFS_RES_HI, j ? {6'h00, code[i][9:8]} : code[i][9:2], "high");
         rd_chk(ARF_OFS_RES_LO, j ? code[i][7:0] : {code[i][1:0], 6'h00}, "low");
         check("irq on done", {31'h0, irq}, 32'h1);
         xfer(ARF_OFS_IRQ_MSK, 1'b1, 8'h00);
         repeat (2) @(posedge clk_sys);
         check("irq masked", {31'h0, irq}, 32'h0);
         xfer(ARF_OFS_IRQ_MSK, 1'b1, 8'h01);
         rd_chk(ARF_OFS_IRQ_ST, 8'h01, "status set");
         xfer(ARF_OFS_IRQ_ST, 1'b1, 8'h01);
         repeat (2) @(posedge clk_sys);
         check("irq cleared", {31'h0, irq}, 32'h0);
      end
      check("go length", 32'(act_len[0]), 32'(CONV + 1));
      check("trigger start", 32'(act_len[3]), 32'(CONV + 1));
      check("oscillator delay", 32'(act_len[1] - act_len[0]), 32'(ARF_INSTR_CYC));
      check("oscillator delay b", 32'(act_len[2] - act_len[0]), 32'(ARF_INSTR_CYC));
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      end_of_test();
   end
endmodule
bind arf_top arf_props #(.CONV_CYC(CONV_CYC)) arf_props_inst (.clk_sys(clk_sys), .srst(srst),
   .bus_req(bus_req), .bus_rsp(bus_rsp), .special_trigger(special_trigger),
   .conversion_active(conversion_active), .irq(irq));
